// ### design/bkpt_compare_tag.sv
/*
  Hardware breakpoint comparators, program-fetch tagging and the tag path
  through the instruction queue, with the match and control registers.
  Assumes: one clock I_CLK at 20 MHz; I_RST is the power-on reset; the CPU
  bus cycle, queue and opcode strobes come from logic on I_CLK; the E clock
  and the two tag pins arrive asynchronously and are synchronised here.
*/
`default_nettype none

`include "bkpt_defs.svh"

module bkpt_compare_tag
  import bkpt_pkg::*;
(
  // clock and resets
  input  wire logic            I_CLK,
  input  wire logic            I_RST,
  input  wire logic            I_SYS_RST,
  // register port
  input  wire logic [7:0]      I_ADDR,
  input  wire logic [7:0]      I_WDATA,
  input  wire logic            I_WR,
  input  wire logic            I_RD,
  output logic      [7:0]      O_RDATA,
  // cpu bus cycle under watch
  input  wire logic            I_BUS_VALID,
  input  wire bkpt_bus_cycle_t I_BUS,
  // instruction queue and cpu state
  input  wire logic            I_QUEUE_LOAD,
  input  wire logic            I_QUEUE_ADV,
  input  wire logic            I_QUEUE_FLUSH,
  input  wire logic            I_OPCODE_START,
  input  wire logic            I_OPCODE_ODD,
  input  wire logic            I_HALT_ACTIVE,
  input  wire logic            I_TAG_START_COMMAND,
  // asynchronous pins
  input  wire logic            I_E_BUS_CLOCK,
  input  wire logic            I_DEBUG_WIRE_PIN,
  input  wire logic            I_TAG_LOW_INPUT,
  // low byte strobe pin drive
  input  wire logic            I_LOW_BYTE_STROBE,
  input  wire logic            I_STROBE_WINDOW,
  output logic                 O_LOW_BYTE_STROBE_OUT,
  output logic                 O_LOW_BYTE_STROBE_OE,
  // requests to the cpu and debug logic
  output logic                 O_BREAK_MATCH,
  output logic                 O_DEBUG_HALT_REQ,
  output logic                 O_SWI_REQ,
  output logic                 O_TAG_ACTIVE
);

  // registers
  logic [7:0]             ctrl0_reg;
  logic [7:0]             ctrl1_reg;
  logic [7:0]             break_addr_high_reg;
  logic [7:0]             break_addr_low_reg;
  logic [7:0]             break_second_high_reg;
  logic [7:0]             break_second_low_reg;
  logic [1:0]             hit_sticky_reg;
  logic [1:0]             hit_sticky_next;
  logic [7:0]             rdata_reg;
  logic [7:0]             rdata_next;

  // pin synchroniser
  logic [2:0]             pin_sync1_reg;
  logic [2:0]             pin_sync2_reg;
  logic [2:0]             pin_sync3_reg;
  logic [2:0]             pin_state_reg;
  logic [2:0]             pin_state_next;
  logic                   e_fall;

  // tagging
  bkpt_tag_state_t        tag_state_reg;
  bkpt_tag_state_t        tag_state_next;
  logic                   tag_active;
  logic [1:0]             pin_tag_reg;
  logic [1:0]             pin_tag_next;
  logic [1:0]             prog_halt_tag_reg;
  logic [1:0]             prog_swi_tag_reg;
  logic [1:0]             prog_halt_tag_next;
  logic [1:0]             prog_swi_tag_next;

  // queue
  bkpt_queue_entry_t      queue_reg  [`BKPT_QUEUE_DEPTH];
  bkpt_queue_entry_t      queue_next [`BKPT_QUEUE_DEPTH];
  logic [1:0]             count_reg;
  logic [1:0]             count_next;
  bkpt_queue_entry_t      push_entry;

  // comparators
  bkpt_mode_t             mode;
  logic                   prog_only;
  logic                   bp0_addr_hit;
  logic                   bp1_addr_hit;
  logic                   data_ok;
  logic                   dir0_ok;
  logic                   dir1_ok;
  logic                   hit0;
  logic                   hit1;
  logic                   immediate_hit;
  logic [1:0]             fetch_byte;

  // requests
  logic                   pending_reg;
  logic                   pending_next;
  logic                   head_halt;
  logic                   head_swi;
  logic                   break_match_reg;
  logic                   halt_req_reg;
  logic                   swi_req_reg;
  logic                   strobe_out_reg;
  logic                   strobe_oe_reg;

  function automatic logic byte_eq(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction : byte_eq

  function automatic logic dir_ok(input logic qualify, input logic value, input logic rw);
    return !qualify || (value == rw);
  endfunction : dir_ok

  function automatic logic agreed(input logic s2, input logic s3, input logic held);
    return (s2 == s3) ? s3 : held;
  endfunction : agreed

  // register writes: control registers follow every reset
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      ctrl0_reg <= `BKPT_RESET_BYTE;
      ctrl1_reg <= `BKPT_RESET_BYTE;
    end else if (I_SYS_RST) begin
      ctrl0_reg <= `BKPT_RESET_BYTE;
      ctrl1_reg <= `BKPT_RESET_BYTE;
    end else if (I_WR) begin
      if (I_ADDR == `BKPT_OFF_CTRL0) begin
        ctrl0_reg <= I_WDATA & `BKPT_CTRL0_WMASK;
      end
      if (I_ADDR == `BKPT_OFF_CTRL1) begin
        ctrl1_reg <= I_WDATA & `BKPT_CTRL1_WMASK;
      end
    end
  end

  // match registers: only the power-on reset clears them
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      break_addr_high_reg   <= `BKPT_RESET_BYTE;
      break_addr_low_reg    <= `BKPT_RESET_BYTE;
      break_second_high_reg <= `BKPT_RESET_BYTE;
      break_second_low_reg  <= `BKPT_RESET_BYTE;
    end else if (I_WR) begin
      unique case (I_ADDR)
        `BKPT_OFF_ADDR_HIGH:   break_addr_high_reg   <= I_WDATA;
        `BKPT_OFF_ADDR_LOW:    break_addr_low_reg    <= I_WDATA;
        `BKPT_OFF_SECOND_HIGH: break_second_high_reg <= I_WDATA;
        `BKPT_OFF_SECOND_LOW:  break_second_low_reg  <= I_WDATA;
        default: ;
      endcase
    end
  end

  // read data stand only in the cycle after the read strobe
  always_comb begin
    rdata_next = `BKPT_RESET_BYTE;
    if (I_RD) begin
      unique case (I_ADDR)
        `BKPT_OFF_CTRL0:       rdata_next = ctrl0_reg;
        `BKPT_OFF_CTRL1:       rdata_next = ctrl1_reg;
        `BKPT_OFF_ADDR_HIGH:   rdata_next = break_addr_high_reg;
        `BKPT_OFF_ADDR_LOW:    rdata_next = break_addr_low_reg;
        `BKPT_OFF_SECOND_HIGH: rdata_next = break_second_high_reg;
        `BKPT_OFF_SECOND_LOW:  rdata_next = break_second_low_reg;
        `BKPT_OFF_STATUS: begin
          rdata_next[`BKPT_ST_TAG_ACTIVE] = tag_active;
          rdata_next[`BKPT_ST_PENDING]    = pending_reg;
          rdata_next[`BKPT_ST_BP0_HIT]    = hit_sticky_reg[0];
          rdata_next[`BKPT_ST_BP1_HIT]    = hit_sticky_reg[1];
        end
        default: rdata_next = `BKPT_RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rdata_reg <= `BKPT_RESET_BYTE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // sticky hit flags: writing one clears, a new hit wins
  always_comb begin
    hit_sticky_next = hit_sticky_reg;
    if (I_WR && I_ADDR == `BKPT_OFF_STATUS) begin
      hit_sticky_next[0] = hit_sticky_reg[0] & ~I_WDATA[`BKPT_ST_BP0_HIT];
      hit_sticky_next[1] = hit_sticky_reg[1] & ~I_WDATA[`BKPT_ST_BP1_HIT];
    end
    hit_sticky_next = hit_sticky_next | {hit1, hit0};
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      hit_sticky_reg <= 2'h0;
    end else if (I_SYS_RST) begin
      hit_sticky_reg <= 2'h0;
    end else begin
      hit_sticky_reg <= hit_sticky_next;
    end
  end

  // three-stage pin synchroniser; a level counts once stages two and three agree
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pin_sync1_reg <= 3'h7;
      pin_sync2_reg <= 3'h7;
      pin_sync3_reg <= 3'h7;
      pin_state_reg <= 3'h7;
    end else begin
      pin_sync1_reg <= {I_E_BUS_CLOCK, I_DEBUG_WIRE_PIN, I_TAG_LOW_INPUT};
      pin_sync2_reg <= pin_sync1_reg;
      pin_sync3_reg <= pin_sync2_reg;
      pin_state_reg <= pin_state_next;
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_state_next[i] = agreed(pin_sync2_reg[i], pin_sync3_reg[i], pin_state_reg[i]);
    end
  end

  assign e_fall = pin_state_reg[`BKPT_PIN_E_CLOCK] & ~pin_state_next[`BKPT_PIN_E_CLOCK];

  // tag enable: started by the command, stopped by the halt state
  always_comb begin
    tag_state_next = tag_state_reg;
    unique case (tag_state_reg)
      BKPT_TAG_IDLE: begin
        if (I_TAG_START_COMMAND && !I_HALT_ACTIVE) begin
          tag_state_next = BKPT_TAG_ACTIVE;
        end
      end
      BKPT_TAG_ACTIVE: begin
        if (I_HALT_ACTIVE) begin
          tag_state_next = BKPT_TAG_IDLE;
        end
      end
      default: tag_state_next = BKPT_TAG_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      tag_state_reg <= BKPT_TAG_IDLE;
    end else if (I_SYS_RST) begin
      tag_state_reg <= BKPT_TAG_IDLE;
    end else begin
      tag_state_reg <= tag_state_next;
    end
  end

  assign tag_active = (tag_state_reg == BKPT_TAG_ACTIVE);

  // pin tags caught at the E fall, held until the word enters the queue
  always_comb begin
    pin_tag_next = I_QUEUE_LOAD ? 2'h0 : pin_tag_reg;
    if (e_fall && tag_active) begin
      pin_tag_next[`BKPT_TAG_HIGH_BYTE] = pin_tag_next[`BKPT_TAG_HIGH_BYTE] |
                                          ~pin_state_next[`BKPT_PIN_TAG_HIGH];
      pin_tag_next[`BKPT_TAG_LOW_BYTE]  = pin_tag_next[`BKPT_TAG_LOW_BYTE] |
                                          ~pin_state_next[`BKPT_PIN_TAG_LOW];
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pin_tag_reg <= 2'h0;
    end else if (I_SYS_RST) begin
      pin_tag_reg <= 2'h0;
    end else begin
      pin_tag_reg <= pin_tag_next;
    end
  end

  // breakpoint comparators
  assign mode      = bkpt_mode_t'(ctrl0_reg[`BKPT_C0_MODE_MSB:`BKPT_C0_MODE_LSB]);
  assign prog_only = ctrl0_reg[`BKPT_C0_PROG_ONLY] || (mode == BKPT_MODE_SWI_DUAL);

  assign bp0_addr_hit = byte_eq(I_BUS.addr[15:8], break_addr_high_reg) &&
                        (!ctrl0_reg[`BKPT_C0_BP0_LOW] ||
                         byte_eq(I_BUS.addr[7:0], break_addr_low_reg));

  assign bp1_addr_hit = ctrl1_reg[`BKPT_C1_SECOND_EN] &&
                        byte_eq(I_BUS.addr[15:8], break_second_high_reg) &&
                        (!ctrl0_reg[`BKPT_C0_BP1_LOW] ||
                         byte_eq(I_BUS.addr[7:0], break_second_low_reg));

  assign data_ok = !ctrl1_reg[`BKPT_C1_SECOND_EN] ||
                   ((ctrl1_reg[`BKPT_C1_HIGH_MASK] ||
                     byte_eq(I_BUS.data[15:8], break_second_high_reg)) &&
                    (ctrl1_reg[`BKPT_C1_LOW_MASK] ||
                     byte_eq(I_BUS.data[7:0], break_second_low_reg)));

  assign dir0_ok = dir_ok(ctrl1_reg[`BKPT_C1_BP0_QUAL], ctrl1_reg[`BKPT_C1_BP0_DIR], I_BUS.rw);
  assign dir1_ok = dir_ok(ctrl1_reg[`BKPT_C1_BP1_QUAL], ctrl1_reg[`BKPT_C1_BP1_DIR], I_BUS.rw);

  always_comb begin
    hit0 = 1'b0;
    hit1 = 1'b0;
    if (I_BUS_VALID && !I_HALT_ACTIVE && (!prog_only || I_BUS.prog)) begin
      unique case (mode)
        BKPT_MODE_OFF: begin
          hit0 = 1'b0;
          hit1 = 1'b0;
        end
        BKPT_MODE_SWI_DUAL: begin
          hit0 = bp0_addr_hit;
          hit1 = bp1_addr_hit;
        end
        BKPT_MODE_HALT_FULL: begin
          hit0 = bp0_addr_hit && (prog_only || (data_ok && dir0_ok));
        end
        BKPT_MODE_HALT_DUAL: begin
          hit0 = bp0_addr_hit && (prog_only || dir0_ok);
          hit1 = bp1_addr_hit && (prog_only || dir1_ok);
        end
      endcase
    end
  end

  assign immediate_hit = (hit0 || hit1) && !prog_only;
  assign fetch_byte    = I_BUS.addr[0] ? 2'b01 : 2'b10;

  // program breakpoints become tags on the fetched byte
  always_comb begin
    prog_halt_tag_next = I_QUEUE_LOAD ? 2'h0 : prog_halt_tag_reg;
    prog_swi_tag_next  = I_QUEUE_LOAD ? 2'h0 : prog_swi_tag_reg;
    if ((hit0 || hit1) && prog_only) begin
      if (mode == BKPT_MODE_SWI_DUAL) begin
        prog_swi_tag_next = prog_swi_tag_next | fetch_byte;
      end else begin
        prog_halt_tag_next = prog_halt_tag_next | fetch_byte;
      end
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      prog_halt_tag_reg <= 2'h0;
      prog_swi_tag_reg  <= 2'h0;
    end else if (I_SYS_RST) begin
      prog_halt_tag_reg <= 2'h0;
      prog_swi_tag_reg  <= 2'h0;
    end else begin
      prog_halt_tag_reg <= prog_halt_tag_next;
      prog_swi_tag_reg  <= prog_swi_tag_next;
    end
  end

  // instruction queue of tag marks, one entry per program word
  assign push_entry.halt = pin_tag_reg | prog_halt_tag_reg;
  assign push_entry.swi  = prog_swi_tag_reg;

  always_comb begin
    count_next = count_reg;
    for (int i = 0; i < `BKPT_QUEUE_DEPTH; i++) begin
      queue_next[i] = queue_reg[i];
    end
    if (I_QUEUE_ADV && count_reg != 2'h0) begin
      for (int i = 0; i < `BKPT_QUEUE_DEPTH - 1; i++) begin
        queue_next[i] = queue_reg[i + 1];
      end
      queue_next[`BKPT_QUEUE_DEPTH - 1] = '0;
      count_next = count_reg - 2'h1;
    end
    if (I_QUEUE_LOAD && count_next < 2'(`BKPT_QUEUE_DEPTH)) begin
      queue_next[count_next] = push_entry;
      count_next = count_next + 2'h1;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      count_reg <= 2'h0;
      for (int i = 0; i < `BKPT_QUEUE_DEPTH; i++) begin
        queue_reg[i] <= '0;
      end
    end else if (I_SYS_RST || I_QUEUE_FLUSH) begin
      count_reg <= 2'h0;
      for (int i = 0; i < `BKPT_QUEUE_DEPTH; i++) begin
        queue_reg[i] <= '0;
      end
    end else begin
      count_reg <= count_next;
      for (int i = 0; i < `BKPT_QUEUE_DEPTH; i++) begin
        queue_reg[i] <= queue_next[i];
      end
    end
  end

  // head of queue: the opcode byte picks the high or low mark
  assign head_halt = (count_reg != 2'h0) &&
                     queue_reg[0].halt[I_OPCODE_ODD ? `BKPT_TAG_LOW_BYTE : `BKPT_TAG_HIGH_BYTE];
  assign head_swi  = (count_reg != 2'h0) &&
                     queue_reg[0].swi[I_OPCODE_ODD ? `BKPT_TAG_LOW_BYTE : `BKPT_TAG_HIGH_BYTE];

  // immediate break waits for the next instruction boundary; a new hit wins
  always_comb begin
    pending_next = pending_reg;
    if (I_OPCODE_START || I_HALT_ACTIVE) begin
      pending_next = 1'b0;
    end
    if (immediate_hit) begin
      pending_next = 1'b1;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pending_reg <= 1'b0;
    end else if (I_SYS_RST) begin
      pending_reg <= 1'b0;
    end else begin
      pending_reg <= pending_next;
    end
  end

  // requests to the cpu, one-cycle pulses
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      break_match_reg <= 1'b0;
      halt_req_reg    <= 1'b0;
      swi_req_reg     <= 1'b0;
    end else if (I_SYS_RST) begin
      break_match_reg <= 1'b0;
      halt_req_reg    <= 1'b0;
      swi_req_reg     <= 1'b0;
    end else begin
      break_match_reg <= hit0 || hit1;
      halt_req_reg    <= I_OPCODE_START && !I_HALT_ACTIVE && (head_halt || pending_reg);
      swi_req_reg     <= I_OPCODE_START && !I_HALT_ACTIVE && !head_halt && !pending_reg && head_swi;
    end
  end

  // shared low tag pin: strobe driven only inside its window while tagging
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      strobe_out_reg <= 1'b0;
      strobe_oe_reg  <= 1'b0;
    end else begin
      strobe_out_reg <= I_LOW_BYTE_STROBE;
      strobe_oe_reg  <= !tag_active || I_STROBE_WINDOW;
    end
  end

  assign O_RDATA               = rdata_reg;
  assign O_BREAK_MATCH         = break_match_reg;
  assign O_DEBUG_HALT_REQ      = halt_req_reg;
  assign O_SWI_REQ             = swi_req_reg;
  assign O_TAG_ACTIVE          = tag_active;
  assign O_LOW_BYTE_STROBE_OUT = strobe_out_reg;
  assign O_LOW_BYTE_STROBE_OE  = strobe_oe_reg;

endmodule : bkpt_compare_tag

`default_nettype wire

// ### design/bkpt_defs.svh
/*
  Register offsets, field positions, reset values and fixed sizes of the
  breakpoint compare and instruction tagging block.
  Assumes inclusion by bare name from the package and the design module.
*/
`ifndef BKPT_DEFS_SVH
`define BKPT_DEFS_SVH

// register offsets on the byte-wide register port
`define BKPT_OFF_CTRL0        8'h20
`define BKPT_OFF_CTRL1        8'h21
`define BKPT_OFF_ADDR_HIGH    8'h22
`define BKPT_OFF_ADDR_LOW     8'h23
`define BKPT_OFF_SECOND_HIGH  8'h24
`define BKPT_OFF_SECOND_LOW   8'h25
`define BKPT_OFF_STATUS       8'h26

// reset values and writable-bit masks
`define BKPT_RESET_BYTE       8'h00
`define BKPT_CTRL0_WMASK      8'hEC
`define BKPT_CTRL1_WMASK      8'h7F

// control 0 fields
`define BKPT_C0_MODE_MSB      7
`define BKPT_C0_MODE_LSB      6
`define BKPT_C0_PROG_ONLY     5
`define BKPT_C0_BP1_LOW       3
`define BKPT_C0_BP0_LOW       2

// control 1 fields
`define BKPT_C1_SECOND_EN     6
`define BKPT_C1_HIGH_MASK     5
`define BKPT_C1_LOW_MASK      4
`define BKPT_C1_BP1_QUAL      3
`define BKPT_C1_BP1_DIR       2
`define BKPT_C1_BP0_QUAL      1
`define BKPT_C1_BP0_DIR       0

// status fields
`define BKPT_ST_TAG_ACTIVE    0
`define BKPT_ST_PENDING       1
`define BKPT_ST_BP0_HIT       2
`define BKPT_ST_BP1_HIT       3

// pin synchroniser bit order
`define BKPT_PIN_E_CLOCK      2
`define BKPT_PIN_TAG_HIGH     1
`define BKPT_PIN_TAG_LOW      0

// tag pair bit order, and queue size in program words
`define BKPT_TAG_HIGH_BYTE    1
`define BKPT_TAG_LOW_BYTE     0
`define BKPT_QUEUE_DEPTH      3
`define BKPT_RW_READ          1'b1

`endif

// ### design/bkpt_pkg.sv
/*
  Types shared by the breakpoint compare and instruction tagging block.
  Assumes bkpt_defs.svh is on the include path.
*/
`default_nettype none

package bkpt_pkg;
  `include "bkpt_defs.svh"

  typedef enum logic [1:0] {
    BKPT_MODE_OFF        = 2'h0,
    BKPT_MODE_SWI_DUAL   = 2'h1,
    BKPT_MODE_HALT_FULL  = 2'h2,
    BKPT_MODE_HALT_DUAL  = 2'h3
  } bkpt_mode_t;

  typedef enum logic [1:0] {
    BKPT_TAG_IDLE   = 2'b01,
    BKPT_TAG_ACTIVE = 2'b10
  } bkpt_tag_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
    logic        rw;
    logic        prog;
  } bkpt_bus_cycle_t;

  typedef struct packed {
    logic [1:0] halt;
    logic [1:0] swi;
  } bkpt_queue_entry_t;

endpackage : bkpt_pkg

`default_nettype wire

// ### tb/bkpt_compare_tag_asserts.sv
/* port checker of the breakpoint and tag block
   assumes binding into bkpt_compare_tag */
`default_nettype none
module bkpt_compare_tag_asserts (
  // clock and resets
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_SYS_RST,
  // inputs
  input wire logic I_BUS_VALID,
  input wire logic I_OPCODE_START,
  input wire logic I_HALT_ACTIVE,
  input wire logic I_TAG_START_COMMAND,
  input wire logic I_STROBE_WINDOW,
  // outputs
  input wire logic O_LOW_BYTE_STROBE_OE,
  input wire logic O_BREAK_MATCH,
  input wire logic O_DEBUG_HALT_REQ,
  input wire logic O_TAG_ACTIVE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  property p_match_cause; O_BREAK_MATCH |-> $past(I_BUS_VALID) && !$past(I_HALT_ACTIVE); endproperty
  a_match_cause: assert property (p_match_cause) else $error("match without bus cycle");
  property p_tag_halt; $past(I_HALT_ACTIVE) |-> !O_TAG_ACTIVE; endproperty
  a_tag_halt: assert property (p_tag_halt) else $error("tagging kept in halt");
  property p_tag_start; I_TAG_START_COMMAND && !I_HALT_ACTIVE && !I_SYS_RST |=> O_TAG_ACTIVE; endproperty
  a_tag_start: assert property (p_tag_start) else $error("tagging not started");
  property p_tag_rise; $rose(O_TAG_ACTIVE) |-> $past(I_TAG_START_COMMAND); endproperty
  a_tag_rise: assert property (p_tag_rise) else $error("tagging started unasked");
  property p_tag_hold; O_TAG_ACTIVE && !I_HALT_ACTIVE && !I_SYS_RST |=> O_TAG_ACTIVE; endproperty
  a_tag_hold: assert property (p_tag_hold) else $error("tagging dropped");
  property p_oe_win; $past(I_STROBE_WINDOW) && !$past(I_SYS_RST) |-> O_LOW_BYTE_STROBE_OE; endproperty
  a_oe_win: assert property (p_oe_win) else $error("strobe not driven in window");
  property p_oe_off; $past(O_TAG_ACTIVE) && !$past(I_STROBE_WINDOW) |-> !O_LOW_BYTE_STROBE_OE; endproperty
  a_oe_off: assert property (p_oe_off) else $error("strobe driven over tag");
  property p_halt_cause; O_DEBUG_HALT_REQ |-> $past(I_OPCODE_START); endproperty
  a_halt_cause: assert property (p_halt_cause) else $error("halt request off boundary");
endmodule : bkpt_compare_tag_asserts
bind bkpt_compare_tag bkpt_compare_tag_asserts bkpt_compare_tag_asserts_inst (.*);
`default_nettype wire

// ### tb/bkpt_tag_host.sv
/* development system model: e clock and tag pins
   assumes calls of tag_word from the bench */
`default_nettype none
module bkpt_tag_host (
  // clock
  input  wire logic i_clk,
  // pins
  output var logic  o_e_clk,
  output var logic  o_tag_high,
  output var logic  o_tag_low
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {o_e_clk, o_tag_high, o_tag_low} = 3'b111;
  // one e cycle; levels set well before the fall and held after it
  task tag_word(input logic hi, input logic lo);
    repeat (2) @(posedge i_clk);
    {o_tag_high, o_tag_low} <= {hi, lo};
    repeat (6) @(posedge i_clk);
    o_e_clk <= 1'b0;
    repeat (8) @(posedge i_clk);
    {o_tag_high, o_tag_low} <= 2'b11;
    o_e_clk <= 1'b1;
    @(posedge i_clk);
  endtask : tag_word
endmodule : bkpt_tag_host
`default_nettype wire

// ### tb/tb_bkpt_compare_tag.sv
/* self-checking bench of the breakpoint and tag block
   assumes the host model drives e clock and tag pins */
`default_nettype none
module tb_bkpt_compare_tag import bkpt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, srst = 1'b0, wr = 1'b0, rd = 1'b0, vld = 1'b0, ld = 1'b0, adv = 1'b0;
  logic fl = 1'b0, ops = 1'b0, odd = 1'b0, halt = 1'b0, cmd = 1'b0, stb = 1'b0, win = 1'b0;
  logic e_clk, t_hi, t_lo, stb_o, stb_oe, bm, hreq, sreq, tact;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
  bkpt_bus_cycle_t bus = '0;
  int num_errors = 0, checked = 0;
  wire logic t_lo_w = stb_oe ? stb_o : t_lo;
  always #25 clk = ~clk;
  bkpt_compare_tag bkpt_compare_tag_inst (.I_CLK(clk), .I_RST(rst), .I_SYS_RST(srst), .I_ADDR(addr),
    .I_WDATA(wd), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_BUS_VALID(vld), .I_BUS(bus), .I_QUEUE_LOAD(ld),
    .I_QUEUE_ADV(adv), .I_QUEUE_FLUSH(fl), .I_OPCODE_START(ops), .I_OPCODE_ODD(odd), .I_HALT_ACTIVE(halt),
    .I_TAG_START_COMMAND(cmd), .I_E_BUS_CLOCK(e_clk), .I_DEBUG_WIRE_PIN(t_hi), .I_TAG_LOW_INPUT(t_lo_w),
    .I_LOW_BYTE_STROBE(stb), .I_STROBE_WINDOW(win), .O_LOW_BYTE_STROBE_OUT(stb_o),
    .O_LOW_BYTE_STROBE_OE(stb_oe), .O_BREAK_MATCH(bm), .O_DEBUG_HALT_REQ(hreq), .O_SWI_REQ(sreq),
    .O_TAG_ACTIVE(tact));
  bkpt_tag_host bkpt_tag_host_inst (.i_clk(clk), .o_e_clk(e_clk), .o_tag_high(t_hi), .o_tag_low(t_lo));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict;
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {wr, addr, wd} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd_chk
  task automatic bus_chk(input logic [15:0] a, input logic [15:0] d, input logic w, input logic exp);
    @(posedge clk);
    {vld, bus} <= {1'b1, a, d, w, 1'b0};
    @(posedge clk);
    vld <= 1'b0;
    #1 chk(bm, exp);
  endtask : bus_chk
  task automatic op_chk(input logic o, input logic exp);
    @(posedge clk);
    {ops, odd} <= {1'b1, o};
    @(posedge clk);
    ops <= 1'b0;
    #1 chk(hreq, exp);
  endtask : op_chk
  task automatic q(input logic l, input logic a, input logic f);
    @(posedge clk);
    {ld, adv, fl} <= {l, a, f};
    @(posedge clk);
    {ld, adv, fl} <= 3'b000;
  endtask : q
  task automatic sys_pulse;
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
  endtask : sys_pulse
  task automatic t_regs;
    logic [7:0] a;
    for (a = 8'h22; a < 8'h26; a++) rd_chk(a, 8'h00);
    for (a = 8'h22; a < 8'h26; a++) wr_reg(a, a ^ 8'hA5);
    sys_pulse();
    for (a = 8'h22; a < 8'h26; a++) rd_chk(a, a ^ 8'hA5);
    rd_chk(8'h30, 8'h00);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (a = 8'h22; a < 8'h26; a++) rd_chk(a, 8'h00);
  endtask : t_regs
  task automatic t_full;
    wr_reg(8'h22, 8'h12);
    wr_reg(8'h23, 8'h34);
    wr_reg(8'h24, 8'hAB);
    wr_reg(8'h25, 8'hCD);
    wr_reg(8'h20, 8'h80);
    bus_chk(16'h12FF, 16'h0000, 1'b0, 1'b1);
    bus_chk(16'h13FF, 16'h0000, 1'b0, 1'b0);
    wr_reg(8'h20, 8'h84);
    bus_chk(16'h12FF, 16'h0000, 1'b0, 1'b0);
    bus_chk(16'h1234, 16'h0000, 1'b0, 1'b1);
    wr_reg(8'h21, 8'h03);
    bus_chk(16'h1234, 16'h0000, 1'b0, 1'b0);
    bus_chk(16'h1234, 16'h0000, 1'b1, 1'b1);
    wr_reg(8'h21, 8'h01);
    bus_chk(16'h1234, 16'h0000, 1'b0, 1'b1);
    wr_reg(8'h21, 8'h40);
    bus_chk(16'h1234, 16'hABCD, 1'b0, 1'b1);
    bus_chk(16'h1234, 16'hAB00, 1'b0, 1'b0);
    bus_chk(16'h1234, 16'h00CD, 1'b0, 1'b0);
    wr_reg(8'h21, 8'h50);
    bus_chk(16'h1234, 16'hAB00, 1'b0, 1'b1);
    halt <= 1'b1;
    bus_chk(16'h1234, 16'hABCD, 1'b0, 1'b0);
    halt <= 1'b0;
    wr_reg(8'h20, 8'h00);
    bus_chk(16'h1234, 16'hABCD, 1'b0, 1'b0);
  endtask : t_full
  task automatic t_dual;
    sys_pulse();
    wr_reg(8'h24, 8'h56);
    wr_reg(8'h25, 8'h78);
    wr_reg(8'h20, 8'hC0);
    wr_reg(8'h21, 8'h4C);
    bus_chk(16'h5600, 16'h0000, 1'b1, 1'b1);
    bus_chk(16'h5600, 16'h0000, 1'b0, 1'b0);
    wr_reg(8'h21, 8'h0C);
    bus_chk(16'h5600, 16'h0000, 1'b1, 1'b0);
    wr_reg(8'h21, 8'h40);
    wr_reg(8'h20, 8'hC8);
    bus_chk(16'h5600, 16'h0000, 1'b1, 1'b0);
    bus_chk(16'h5678, 16'h0000, 1'b0, 1'b1);
    rd_chk(8'h26, 8'h0A);
    op_chk(1'b0, 1'b1);
    op_chk(1'b0, 1'b0);
  endtask : t_dual
  task automatic t_swi;
    sys_pulse();
    wr_reg(8'h20, 8'h40);
    @(posedge clk);
    {vld, bus} <= {1'b1, 16'h1235, 16'h0000, 1'b1, 1'b1};
    @(posedge clk);
    vld <= 1'b0;
    #1 chk(bm, 1'b1);
    q(1'b1, 1'b0, 1'b0);
    op_chk(1'b1, 1'b0);
    chk(sreq, 1'b1);
  endtask : t_swi
  task automatic t_tag;
    sys_pulse();
    bkpt_tag_host_inst.tag_word(1'b0, 1'b0);
    q(1'b1, 1'b0, 1'b0);
    op_chk(1'b0, 1'b0);
    @(posedge clk);
    cmd <= 1'b1;
    @(posedge clk);
    {cmd, win, stb} <= 3'b011;
    #1 chk(tact, 1'b1);
    @(posedge clk);
    {win, stb} <= 2'b00;
    #1 chk(stb_oe, 1'b1);
    chk(stb_o, 1'b1);
    for (int k = 0; k < 8; k++) begin
      q(1'b0, 1'b0, 1'b1);
      bkpt_tag_host_inst.tag_word(k[0], k[1]);
      q(1'b1, 1'b0, 1'b0);
      op_chk(k[2], !(k[2] ? k[1] : k[0]));
    end
    q(1'b0, 1'b0, 1'b1);
    bkpt_tag_host_inst.tag_word(1'b1, 1'b1);
    q(1'b1, 1'b0, 1'b0);
    bkpt_tag_host_inst.tag_word(1'b0, 1'b1);
    q(1'b1, 1'b0, 1'b0);
    op_chk(1'b0, 1'b0);
    q(1'b0, 1'b1, 1'b0);
    op_chk(1'b0, 1'b1);
    @(posedge clk);
    halt <= 1'b1;
    @(posedge clk);
    halt <= 1'b0;
    #1 chk(tact, 1'b0);
    q(1'b0, 1'b0, 1'b1);
    bkpt_tag_host_inst.tag_word(1'b0, 1'b0);
    q(1'b1, 1'b0, 1'b0);
    op_chk(1'b0, 1'b0);
  endtask : t_tag
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_full();
    t_dual();
    t_swi();
    t_tag();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
endmodule : tb_bkpt_compare_tag
`default_nettype wire
